// ==== logic/supply_level_monitor_regs.sv ====
// register and interrupt logic of the supply level monitor
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

module supply_level_monitor_regs
   import slm_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   // register port
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   // brown-out detector
   input wire logic [1:0] BROWNOUT_MODE,
   input wire logic BROWNOUT_SAMPLE,
   input wire logic [LEVEL_W-1:0] BROWNOUT_LEVEL_SEL,
   // analog comparator
   input wire logic CMP_BELOW,
   output logic [THRESH_W-1:0] THRESHOLD_SEL,
   // interrupt
   output logic IRQ
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [1:0] threshold_margin_sel;
   logic [1:0] next_threshold_margin_sel;
   logic [1:0] crossing_event_sel;
   logic [1:0] next_crossing_event_sel;
   logic monitor_irq_enable;
   logic next_monitor_irq_enable;
   logic monitor_irq_flag;
   logic next_monitor_irq_flag;
   logic below_threshold_state;
   logic next_below_threshold_state;
   logic [THRESH_W-1:0] thresh;
   logic [THRESH_W-1:0] next_thresh;
   logic irq;
   logic next_irq;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] next_rdata;
   logic cmp_meta;
   logic cmp_sync;
   logic wr_level;
   logic wr_ctrl;
   logic wr_flags;
   logic rd_flags;
   logic rd_status;
   logic enabled;
   logic evaluate;
   logic event_hit;
   logic flag_clear;

   assign RDATA = rdata;
   assign THRESHOLD_SEL = thresh;
   assign IRQ = irq;

   ////////////////////////////////////////////////////////////////////////////////
   // comparator synchroniser

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
      end else begin
         cmp_meta <= CMP_BELOW;
         cmp_sync <= cmp_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // decode

   assign wr_level = WR && (ADDR == ADDR_LEVEL_CTRL);
   assign wr_ctrl = WR && (ADDR == ADDR_IRQ_CTRL);
   assign wr_flags = WR && (ADDR == ADDR_IRQ_FLAGS);
   assign rd_flags = RD && (ADDR == ADDR_IRQ_FLAGS);
   assign rd_status = RD && (ADDR == ADDR_STATUS);

   // monitor runs only with the detector on, sampled mode only at strobes
   assign enabled = (bo_mode_t'(BROWNOUT_MODE) != BO_OFF);
   assign evaluate = enabled && ((bo_mode_t'(BROWNOUT_MODE) != BO_SAMPLED) || BROWNOUT_SAMPLE);

   always_comb begin
      case (crossing_t'(crossing_event_sel))
         EV_FALL: begin
            event_hit = evaluate && !below_threshold_state && cmp_sync;
         end
         EV_RISE: begin
            event_hit = evaluate && below_threshold_state && !cmp_sync;
         end
         EV_CROSS: begin
            event_hit = evaluate && (below_threshold_state != cmp_sync);
         end
         default: begin
            event_hit = 1'b0;
         end
      endcase
   end

   // read of the flag register also clears it
   assign flag_clear = (wr_flags && WDATA[FLAG_BIT]) || rd_flags;

   ////////////////////////////////////////////////////////////////////////////////
   // control and state registers

   always_comb begin
      next_threshold_margin_sel = threshold_margin_sel;
      next_crossing_event_sel = crossing_event_sel;
      next_monitor_irq_enable = monitor_irq_enable;
      next_monitor_irq_flag = monitor_irq_flag;
      next_below_threshold_state = below_threshold_state;
      if (wr_level) begin
         next_threshold_margin_sel = WDATA[MARGIN_LSB+:2];
      end
      if (wr_ctrl) begin
         next_monitor_irq_enable = WDATA[IE_BIT];
         next_crossing_event_sel = WDATA[EVSEL_LSB+:2];
      end
      if (evaluate) begin
         next_below_threshold_state = cmp_sync;
      end
      if (flag_clear) begin
         next_monitor_irq_flag = 1'b0;
      end
      if (event_hit) begin
         next_monitor_irq_flag = 1'b1;
      end
      // threshold always relative to the live brown-out level
      next_thresh = {BROWNOUT_LEVEL_SEL, next_threshold_margin_sel};
      next_irq = next_monitor_irq_flag && next_monitor_irq_enable && enabled;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         threshold_margin_sel <= MARGIN_RST;
         crossing_event_sel <= EVSEL_RST;
         monitor_irq_enable <= IE_RST;
         monitor_irq_flag <= FLAG_RST;
         below_threshold_state <= BELOW_RST;
         thresh <= '0;
         irq <= 1'b0;
      end else begin
         threshold_margin_sel <= next_threshold_margin_sel;
         crossing_event_sel <= next_crossing_event_sel;
         monitor_irq_enable <= next_monitor_irq_enable;
         monitor_irq_flag <= next_monitor_irq_flag;
         below_threshold_state <= next_below_threshold_state;
         thresh <= next_thresh;
         irq <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, valid only in the cycle after the strobe

   always_comb begin
      next_rdata = RDATA_RST;
      if (RD) begin
         case (ADDR)
            ADDR_LEVEL_CTRL: begin
               next_rdata[MARGIN_LSB+:2] = threshold_margin_sel;
            end
            ADDR_IRQ_CTRL: begin
               next_rdata[IE_BIT] = monitor_irq_enable;
               next_rdata[EVSEL_LSB+:2] = crossing_event_sel;
            end
            ADDR_IRQ_FLAGS: begin
               next_rdata[FLAG_BIT] = monitor_irq_flag;
            end
            ADDR_STATUS: begin
               next_rdata[BELOW_BIT] = below_threshold_state;
            end
            default: begin
               next_rdata = RDATA_RST;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata <= RDATA_RST;
      end else begin
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   property p_margin_write;
      @(posedge CLK) disable iff (!RSTN)
      wr_level |=> (threshold_margin_sel == $past(WDATA[1:0])) && (THRESHOLD_SEL[1:0] == $past(WDATA[1:0]));
   endproperty
   a_margin_write: assert property (p_margin_write) else $error("margin write not applied");

   property p_level_follow;
      @(posedge CLK) disable iff (!RSTN)
      1'b1 |=> THRESHOLD_SEL[4:2] == $past(BROWNOUT_LEVEL_SEL);
   endproperty
   a_level_follow: assert property (p_level_follow) else $error("threshold not tied to level");

   property p_reserved_event;
      @(posedge CLK) disable iff (!RSTN)
      (crossing_event_sel == EV_RSVD && !monitor_irq_flag) |=> !monitor_irq_flag;
   endproperty
   a_reserved_event: assert property (p_reserved_event) else $error("reserved select set flag");

   property p_fall_event;
      @(posedge CLK) disable iff (!RSTN)
      (evaluate && crossing_event_sel == EV_FALL && !below_threshold_state && cmp_sync) |=> monitor_irq_flag;
   endproperty
   a_fall_event: assert property (p_fall_event) else $error("fall event missed");

   property p_enable_write;
      @(posedge CLK) disable iff (!RSTN)
      wr_ctrl |=> monitor_irq_enable == $past(WDATA[0]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable write not applied");

   property p_cross_event;
      @(posedge CLK) disable iff (!RSTN)
      (evaluate && crossing_event_sel == EV_CROSS && below_threshold_state != cmp_sync) |=> monitor_irq_flag;
   endproperty
   a_cross_event: assert property (p_cross_event) else $error("cross event missed");

   property p_hold_disabled;
      @(posedge CLK) disable iff (!RSTN)
      (!enabled && !flag_clear) |=> $stable(monitor_irq_flag) && $stable(below_threshold_state);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) else $error("flag moved while detector off");

   property p_status_read;
      @(posedge CLK) disable iff (!RSTN)
      rd_status |=> RDATA == {7'h00, $past(below_threshold_state)};
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_irq_level;
      @(posedge CLK) disable iff (!RSTN)
      (monitor_irq_flag && monitor_irq_enable && enabled)[*2] |-> IRQ;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("request not raised");

   property p_irq_off;
      @(posedge CLK) disable iff (!RSTN)
      !enabled |=> !IRQ;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request while detector off");

   property p_sampled_hold;
      @(posedge CLK) disable iff (!RSTN)
      (enabled && BROWNOUT_MODE == BO_SAMPLED && !BROWNOUT_SAMPLE) |=> $stable(below_threshold_state);
   endproperty
   a_sampled_hold: assert property (p_sampled_hold) else $error("evaluated between samples");

   property p_clear_wins_not;
      @(posedge CLK) disable iff (!RSTN)
      (wr_flags && WDATA[0] && event_hit) |=> monitor_irq_flag;
   endproperty
   a_clear_wins_not: assert property (p_clear_wins_not) else $error("set lost to clear");

   property p_flag_clear;
      @(posedge CLK) disable iff (!RSTN)
      (wr_flags && WDATA[0] && !event_hit) |=> !monitor_irq_flag && !IRQ;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_rise_event;
      @(posedge CLK) disable iff (!RSTN)
      (evaluate && crossing_event_sel == EV_RISE && below_threshold_state && !cmp_sync) |=> monitor_irq_flag;
   endproperty
   a_rise_event: assert property (p_rise_event) else $error("rise event missed");

   property p_status_track;
      @(posedge CLK) disable iff (!RSTN)
      evaluate |=> below_threshold_state == $past(cmp_sync);
   endproperty
   a_status_track: assert property (p_status_track) else $error("status not updated");

   property p_enable_gate;
      @(posedge CLK) disable iff (!RSTN)
      (!monitor_irq_enable && !wr_ctrl) |=> !IRQ;
   endproperty
   a_enable_gate: assert property (p_enable_gate) else $error("request with enable off");

   property p_flag_read;
      @(posedge CLK) disable iff (!RSTN)
      rd_flags |=> RDATA[FLAG_BIT] == $past(monitor_irq_flag);
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

   property p_read_clear;
      @(posedge CLK) disable iff (!RSTN)
      (rd_flags && !event_hit) |=> !monitor_irq_flag;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

   property p_irq_needs_flag;
      @(posedge CLK) disable iff (!RSTN)
      !monitor_irq_flag |-> !IRQ;
   endproperty
   a_irq_needs_flag: assert property (p_irq_needs_flag) else $error("request without flag");

endmodule : supply_level_monitor_regs

// ==== pkg/slm_pkg.sv ====
// constants and types of the supply level monitor register block
package slm_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int LEVEL_W = 3;
   localparam int THRESH_W = 5;

   // register byte offsets
   localparam logic [7:0] ADDR_LEVEL_CTRL = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h09;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0A;
   localparam logic [7:0] ADDR_STATUS = 8'h0B;

   // field positions
   localparam int MARGIN_LSB = 0;
   localparam int IE_BIT = 0;
   localparam int EVSEL_LSB = 1;
   localparam int FLAG_BIT = 0;
   localparam int BELOW_BIT = 0;

   // values after reset
   localparam logic [1:0] MARGIN_RST = 2'h0;
   localparam logic [1:0] EVSEL_RST = 2'h0;
   localparam logic IE_RST = 1'b0;
   localparam logic FLAG_RST = 1'b0;
   localparam logic BELOW_RST = 1'b0;
   localparam logic [7:0] RDATA_RST = 8'h00;

   typedef enum logic [1:0] {
      MARGIN_5PCT = 2'b00,
      MARGIN_15PCT = 2'b01,
      MARGIN_25PCT = 2'b10,
      MARGIN_RSVD = 2'b11
   } margin_t;

   typedef enum logic [1:0] {
      EV_FALL = 2'b00,
      EV_RISE = 2'b01,
      EV_CROSS = 2'b10,
      EV_RSVD = 2'b11
   } crossing_t;

   typedef enum logic [1:0] {
      BO_OFF = 2'b00,
      BO_CONT = 2'b01,
      BO_SAMPLED = 2'b10,
      BO_CONT_WAKE = 2'b11
   } bo_mode_t;

endpackage : slm_pkg

// ==== tb/supply_comparator_model.sv ====
// behavioural analog comparator at the far side of the monitor
`timescale 1ns/1ns

module supply_comparator_model
   import slm_pkg::*;
#(
   parameter int BASE_MV = 1800,
   parameter int STEP_MV = 200
)
(
   // threshold select from the monitor
   input wire logic [THRESH_W-1:0] threshold_sel,
   // supply seen by the comparator, in millivolts
   input wire logic signed [31:0] supply_mv,
   // comparator result
   output logic cmp_below
);

   // threshold in mV: margin on top of the selected brown-out level
   function automatic int thresh_mv(input logic [THRESH_W-1:0] sel);
      int lvl;
      int pct;
      lvl = BASE_MV + STEP_MV * int'(sel[4:2]);
      pct = (sel[1:0] == 2'h0) ? 5 : (sel[1:0] == 2'h1) ? 15 : 25;
      return lvl * (100 + pct) / 100;
   endfunction : thresh_mv

   assign cmp_below = (supply_mv < thresh_mv(threshold_sel));

endmodule : supply_comparator_model

// ==== tb/tb.sv ====
// self-checking testbench of the supply level monitor registers
`timescale 1ns/1ns

module tb;
   import slm_pkg::*;

   logic CLK, RSTN, WR, RD, BROWNOUT_SAMPLE, CMP_BELOW, IRQ;
   logic [7:0] ADDR, WDATA, RDATA;
   logic [1:0] BROWNOUT_MODE;
   logic [2:0] BROWNOUT_LEVEL_SEL;
   logic [4:0] THRESHOLD_SEL;
   logic [1:0] ev;
   logic [1:0] m;
   int supply_mv, fail_count, cmp_count;

   supply_level_monitor_regs dut (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .BROWNOUT_MODE(BROWNOUT_MODE), .BROWNOUT_SAMPLE(BROWNOUT_SAMPLE),
      .BROWNOUT_LEVEL_SEL(BROWNOUT_LEVEL_SEL), .CMP_BELOW(CMP_BELOW), .THRESHOLD_SEL(THRESHOLD_SEL), .IRQ(IRQ));

   supply_comparator_model cmp (.threshold_sel(THRESHOLD_SEL), .supply_mv(supply_mv), .cmp_below(CMP_BELOW));

   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end

   ////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
   endtask : rd

   task wait_irq(input logic exp);
      int n;
      n = 0;
      #1;
      while (IRQ !== exp && n < 20) begin
         @(posedge CLK);
         #1 n++;
      end
      chk({7'h00, IRQ}, {7'h00, exp});
      if (IRQ !== exp) stop_test();
   endtask : wait_irq

   // synchroniser plus evaluation latency
   task settle;
      repeat (6) @(posedge CLK);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////////////
   initial begin
      ADDR = 8'h00;
      WDATA = 8'h00;
      WR = 1'b0;
      RD = 1'b0;
      BROWNOUT_MODE = 2'h1;
      BROWNOUT_SAMPLE = 1'b0;
      BROWNOUT_LEVEL_SEL = 3'h2;
      supply_mv = 3000;
      fail_count = 0;
      cmp_count = 0;
      RSTN = 1'b0;
      repeat (8) @(posedge CLK);
      RSTN <= 1'b1;
      rd(ADDR_LEVEL_CTRL, 8'h00);
      rd(ADDR_IRQ_CTRL, 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      rd(ADDR_STATUS, 8'h00);
      rd(8'h30, 8'h00);
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(ADDR_LEVEL_CTRL, {6'h00, m});
         rd(ADDR_LEVEL_CTRL, {6'h00, m});
         chk({3'h0, THRESHOLD_SEL}, {3'h0, BROWNOUT_LEVEL_SEL, m});
      end
      wr(ADDR_LEVEL_CTRL, 8'h00);
      // every event select, falling then rising supply
      for (int i = 0; i < 4; i++) begin
         ev = 2'(i);
         wr(ADDR_IRQ_CTRL, {5'h00, ev, 1'b1});
         rd(ADDR_IRQ_CTRL, {5'h00, ev, 1'b1});
         supply_mv = 2000;
         settle();
         wait_irq(ev == EV_FALL || ev == EV_CROSS);
         rd(ADDR_STATUS, 8'h01);
         rd(ADDR_IRQ_FLAGS, {7'h00, ev == EV_FALL || ev == EV_CROSS});
         rd(ADDR_IRQ_FLAGS, 8'h00);
         chk({7'h00, IRQ}, 8'h00);
         supply_mv = 3000;
         settle();
         wait_irq(ev == EV_RISE || ev == EV_CROSS);
         rd(ADDR_STATUS, 8'h00);
         rd(ADDR_IRQ_FLAGS, {7'h00, ev == EV_RISE || ev == EV_CROSS});
      end
      // enable off, write zero keeps flag, write one clears
      wr(ADDR_IRQ_CTRL, 8'h04);
      supply_mv = 2000;
      settle();
      chk({7'h00, IRQ}, 8'h00);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_IRQ_CTRL, 8'h05);
      wait_irq(1'b1);
      wr(ADDR_IRQ_FLAGS, 8'h01);
      wait_irq(1'b0);
      // threshold follows the brown-out level
      supply_mv = 2500;
      settle();
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h01);
      BROWNOUT_LEVEL_SEL <= 3'h4;
      settle();
      chk({3'h0, THRESHOLD_SEL}, 8'h10);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_IRQ_FLAGS, 8'h01);
      // detector off: flag and status hold, request masked
      BROWNOUT_MODE <= 2'h0;
      supply_mv = 3000;
      settle();
      chk({7'h00, IRQ}, 8'h00);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      // sampled mode: evaluation only at the sample pulse
      BROWNOUT_MODE <= 2'h2;
      settle();
      rd(ADDR_STATUS, 8'h01);
      chk({7'h00, IRQ}, 8'h00);
      @(posedge CLK);
      BROWNOUT_SAMPLE <= 1'b1;
      @(posedge CLK);
      BROWNOUT_SAMPLE <= 1'b0;
      wait_irq(1'b1);
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h01);
      // mode 3 evaluates continuously
      BROWNOUT_MODE <= 2'h3;
      supply_mv = 2000;
      settle();
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_IRQ_FLAGS, 8'h01);
      stop_test();
   end

endmodule : tb
